// File: rtl/lbcs_link.sv
// link-side crc unit, status mux, buffer memory and memory bus controller
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// [R1] frame-end crc error unless residue matches
// [R2] crc input from transmit or receive stream
// [R3] crc register outputs are active low
// [R4] two-bit select picks status word
// [R5] status mux drives bus only when enabled
// [R6] 16k-word memory, sixteen 1536-byte buffers
// [R7] first four buffer bytes hold status
// [R8] port supplies every buffer memory address
// [R9] port arbiter grants among four requesters
// [R10] bus controller handshakes every link word
// [R11] loopback crc serves transmit unless receiver selected
// [R12] residue sampled only on byte boundaries
// [R13] standard 32-bit crc, shift register xor
// [R14] 12-bit saturating receive byte count
// [R15] polynomial 04c11db7, preset all ones
// [R16] one grant per cycle, requests held
module lbcs_link #(
   parameter int MEM_WORDS = lbcs_pkg::MEM_WORDS,
   parameter int FIFO_DEPTH = lbcs_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // mode
   input wire logic loopback,
   input wire logic crc_to_receiver_select,
   // transmit serial side
   input wire logic tx_active,
   input wire logic tx_frame_start,
   input wire logic tx_bit_stb,
   input wire logic tx_bit,
   input wire logic tx_done,
   input wire logic [15:0] tx_stat0,
   input wire logic [15:0] tx_stat1,
   input wire logic [9:0] cable_reflect_time,
   input wire logic tx_word_req,
   output logic tx_word_valid,
   output logic [15:0] tx_word,
   // receive serial side
   input wire logic rx_active,
   input wire logic rx_frame_start,
   input wire logic rx_bit_stb,
   input wire logic rx_bit,
   input wire logic rx_frame_end,
   // crc results and receive overrun flag
   output logic [31:0] crc_out_n,
   output logic crc_error,
   output logic rx_overrun,
   // memory bus handshake to port arbiter
   output logic mem_req,
   output lbcs_pkg::lbcs_memreq_s mem_cmd,
   input wire logic mem_ack,
   input wire logic [13:0] port_addr,
   // port direct access (dma engine, processor)
   input wire logic port_en,
   input wire logic port_we,
   input wire logic [15:0] port_wdata,
   output logic [15:0] port_rdata,
   // status on the memory data bus
   output logic [1:0] stat_sel,
   output logic stat_drive,
   output logic [15:0] stat_bus
);
   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   logic [15:0] mem_reg [MEM_WORDS]; // packet buffer words
   logic [31:0] crc_reg; // crc shift register
   logic [31:0] crc_next;
   logic crc_in; // selected serial bit
   logic crc_stb; // selected bit strobe
   logic crc_rx_side; // crc dedicated to receiver
   logic [2:0] crc_bits_reg; // bit position within byte
   logic resid_ok_reg; // residue seen at last byte boundary
   logic crc_error_reg;
   logic [15:0] rx_shift_reg; // receive word shifter
   logic [3:0] rx_bits_reg; // bits in shifter
   logic [11:0] rx_count_reg; // received bytes
   logic rx_push; // word into fifo
   logic [15:0] rx_push_data;
   logic fifo_in_ready;
   logic fifo_valid;
   logic fifo_pop;
   logic [15:0] fifo_data;
   lbcs_pkg::lbcs_mbc_e mbc_reg;
   lbcs_pkg::lbcs_mbc_e mbc_next;
   logic [1:0] stat_left_reg; // status words still to write
   logic stat_rx_reg; // status belongs to receiver
   logic stat_pend_rx_reg; // rx status queued
   logic stat_pend_tx_reg; // tx status queued
   logic txrd_pend_reg; // transmit read queued
   logic [15:0] tx_word_reg;
   logic tx_word_valid_reg;
   logic [15:0] port_rdata_reg;
   logic overrun_reg;

   // ----------------------------------------------------------------------
   // crc input selection
   // ----------------------------------------------------------------------
   // in loopback both streams run, so a mode bit decides the owner
   assign crc_rx_side = loopback ? crc_to_receiver_select // [R11]
                                 : (rx_active && !tx_active);
   assign crc_in = crc_rx_side ? rx_bit : tx_bit; // [R2]
   assign crc_stb = crc_rx_side ? (rx_active && rx_bit_stb) // [R2]
                                : (tx_active && tx_bit_stb);

   // one serial step of the generator: shift left, xor on feedback
   assign crc_next = {crc_reg[30:0], 1'b0} ^
                     ((crc_reg[31] ^ crc_in) ? lbcs_pkg::CRC_POLY
                                             : 32'h0000_0000); // [R13]

   // ----------------------------------------------------------------------
   // crc register, preset at each frame start of the side it serves
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         crc_reg <= lbcs_pkg::CRC_PRESET;
         crc_bits_reg <= '0;
      end else if (crc_rx_side ? rx_frame_start : tx_frame_start) begin
         crc_reg <= lbcs_pkg::CRC_PRESET; // [R15]
         crc_bits_reg <= '0;
      end else if (crc_stb) begin
         crc_reg <= crc_next; // [R13]
         crc_bits_reg <= crc_bits_reg + 3'h1;
      end
   end

   // downstream logic sees the register inverted
   assign crc_out_n = ~crc_reg; // [R3]

   // ----------------------------------------------------------------------
   // residue detector, strobed only when a byte completes
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst || rx_frame_start) begin
         resid_ok_reg <= 1'b0;
      end else if (crc_stb && crc_bits_reg == 3'h7) begin
         resid_ok_reg <= (crc_next == lbcs_pkg::CRC_RESIDUE); // [R12]
      end
   end

   // error judged at frame end; stray trailing bits do not count
   always_ff @(posedge sys_clk) begin
      if (sys_rst || rx_frame_start) begin
         crc_error_reg <= 1'b0;
      end else if (rx_frame_end) begin
         crc_error_reg <= !resid_ok_reg; // [R1]
      end
   end
   assign crc_error = crc_error_reg;

   // ----------------------------------------------------------------------
   // receive shifter and saturating byte counter
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst || rx_frame_start) begin
         rx_shift_reg <= '0;
         rx_bits_reg <= '0;
         rx_count_reg <= '0;
      end else if (rx_active && rx_bit_stb) begin
         rx_shift_reg <= {rx_bit, rx_shift_reg[15:1]}; // lsb first
         rx_bits_reg <= rx_bits_reg + 4'h1;
         if (rx_bits_reg[2:0] == 3'h7 && rx_count_reg != 12'hFFF) begin
            rx_count_reg <= rx_count_reg + 12'h001; // [R14]
         end
      end
   end

   // whole words go on at 16 bits, an odd last byte at frame end
   assign rx_push = (rx_active && rx_bit_stb && rx_bits_reg == 4'hF) ||
                    (rx_frame_end && rx_bits_reg == 4'h8);
   assign rx_push_data = (rx_bits_reg == 4'h8 && !rx_bit_stb)
                         ? {8'h00, rx_shift_reg[15:8]}
                         : {rx_bit, rx_shift_reg[15:1]};

   // a full fifo loses the word; flag it for the frame
   always_ff @(posedge sys_clk) begin
      if (sys_rst || rx_frame_start) begin
         overrun_reg <= 1'b0;
      end else if (rx_push && !fifo_in_ready) begin
         overrun_reg <= 1'b1;
      end
   end
   assign rx_overrun = overrun_reg;

   // ----------------------------------------------------------------------
   // word fifo between shifter and memory bus
   // ----------------------------------------------------------------------
   lbcs_fifo #(.WIDTH(lbcs_pkg::WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .in_valid(rx_push),
      .in_ready(fifo_in_ready),
      .in_data(rx_push_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   // ----------------------------------------------------------------------
   // pending work for the memory bus controller
   // ----------------------------------------------------------------------
   // a new event wins over the clear that its service would cause
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         stat_pend_rx_reg <= 1'b0;
         stat_pend_tx_reg <= 1'b0;
         txrd_pend_reg <= 1'b0;
      end else begin
         if (rx_frame_end) begin
            stat_pend_rx_reg <= 1'b1;
         end else if (mbc_reg == lbcs_pkg::LBCS_IDLE &&
                      mbc_next == lbcs_pkg::LBCS_STAT &&
                      stat_pend_rx_reg) begin
            stat_pend_rx_reg <= 1'b0;
         end
         if (tx_done) begin
            stat_pend_tx_reg <= 1'b1;
         end else if (mbc_reg == lbcs_pkg::LBCS_IDLE &&
                      mbc_next == lbcs_pkg::LBCS_STAT &&
                      !stat_pend_rx_reg) begin
            stat_pend_tx_reg <= 1'b0;
         end
         if (tx_word_req) begin
            txrd_pend_reg <= 1'b1;
         end else if (mbc_reg == lbcs_pkg::LBCS_TXRD && mem_ack) begin
            txrd_pend_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // memory bus controller next state
   // ----------------------------------------------------------------------
   // data drains before status so status follows the frame's words
   always_comb begin
      mbc_next = mbc_reg;
      case (mbc_reg)
         lbcs_pkg::LBCS_IDLE: begin
            if (fifo_valid) begin
               mbc_next = lbcs_pkg::LBCS_DATA;
            end else if (stat_pend_rx_reg || stat_pend_tx_reg) begin
               mbc_next = lbcs_pkg::LBCS_STAT;
            end else if (txrd_pend_reg) begin
               mbc_next = lbcs_pkg::LBCS_TXRD;
            end
         end
         lbcs_pkg::LBCS_DATA, lbcs_pkg::LBCS_TXRD: begin
            if (mem_ack) begin
               mbc_next = lbcs_pkg::LBCS_IDLE;
            end
         end
         lbcs_pkg::LBCS_STAT: begin
            if (mem_ack && stat_left_reg == 2'h1) begin
               mbc_next = lbcs_pkg::LBCS_IDLE;
            end
         end
         default: mbc_next = lbcs_pkg::LBCS_IDLE;
      endcase
   end

   // ----------------------------------------------------------------------
   // controller state and status sequencing
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         mbc_reg <= lbcs_pkg::LBCS_IDLE;
         stat_left_reg <= '0;
         stat_rx_reg <= 1'b0;
      end else begin
         mbc_reg <= mbc_next;
         if (mbc_reg == lbcs_pkg::LBCS_IDLE &&
             mbc_next == lbcs_pkg::LBCS_STAT) begin
            stat_left_reg <= 2'(lbcs_pkg::STAT_WORDS); // [R7]
            stat_rx_reg <= stat_pend_rx_reg;
         end else if (mbc_reg == lbcs_pkg::LBCS_STAT && mem_ack) begin
            stat_left_reg <= stat_left_reg - 2'h1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // status multiplexer
   // ----------------------------------------------------------------------
   // the active machine picks words 0 then 1 of its own status area
   assign stat_sel = {stat_rx_reg, (stat_left_reg == 2'h1)}; // [R5]
   assign stat_drive = (mbc_reg == lbcs_pkg::LBCS_STAT); // [R5]
   always_comb begin
      stat_bus = 16'h0000; // idle bus is held at zero
      if (stat_drive) begin // [R5]
         case (stat_sel) // [R4]
            lbcs_pkg::SEL_TX_W0: stat_bus = tx_stat0;
            lbcs_pkg::SEL_TX_W1: stat_bus =
               {tx_stat1[15:10], cable_reflect_time};
            lbcs_pkg::SEL_RX_W0: stat_bus =
               16'(crc_error_reg) << lbcs_pkg::RX_CRC_BIT;
            lbcs_pkg::SEL_RX_CNT: stat_bus = {4'h0, rx_count_reg}; // [R14]
            default: stat_bus = 16'h0000;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // request to the port arbiter
   // ----------------------------------------------------------------------
   // held until acknowledged; the port names the address
   assign mem_req = (mbc_reg != lbcs_pkg::LBCS_IDLE); // [R10]
   assign fifo_pop = (mbc_reg == lbcs_pkg::LBCS_DATA) && mem_ack; // [R10]
   always_comb begin
      mem_cmd.kind = lbcs_pkg::LBCS_K_RXDATA;
      mem_cmd.stat_idx = (stat_left_reg == 2'h1);
      mem_cmd.wdata = fifo_data;
      case (mbc_reg)
         lbcs_pkg::LBCS_STAT: begin
            mem_cmd.kind = lbcs_pkg::LBCS_K_STATUS;
            mem_cmd.wdata = stat_bus;
         end
         lbcs_pkg::LBCS_TXRD: mem_cmd.kind = lbcs_pkg::LBCS_K_TXREAD;
         default: mem_cmd.kind = lbcs_pkg::LBCS_K_RXDATA;
      endcase
   end

   // ----------------------------------------------------------------------
   // packet buffer memory, addressed only by the port
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (mem_req && mem_ack && mbc_reg != lbcs_pkg::LBCS_TXRD) begin
         mem_reg[port_addr] <= mem_cmd.wdata; // [R8]
      end else if (!mem_ack && port_en && port_we) begin
         mem_reg[port_addr] <= port_wdata; // [R6]
      end
   end

   // read data for the transmitter and the port
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tx_word_reg <= '0;
         tx_word_valid_reg <= 1'b0;
         port_rdata_reg <= '0;
      end else begin
         tx_word_valid_reg <= (mbc_reg == lbcs_pkg::LBCS_TXRD) && mem_ack;
         if (mbc_reg == lbcs_pkg::LBCS_TXRD && mem_ack) begin
            tx_word_reg <= mem_reg[port_addr]; // [R10]
         end
         if (port_en && !port_we && !mem_ack) begin
            port_rdata_reg <= mem_reg[port_addr];
         end
      end
   end
   assign tx_word = tx_word_reg;
   assign tx_word_valid = tx_word_valid_reg;
   assign port_rdata = port_rdata_reg;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   a_crc_verdict: // [R1]
   assert property (@(posedge sys_clk) disable iff (sys_rst)
      rx_frame_end && !rx_frame_start |=> crc_error == !$past(resid_ok_reg))
   else $error("crc verdict does not follow residue");

   a_crc_preset: // [R15]
   assert property (@(posedge sys_clk) disable iff (sys_rst)
      (crc_rx_side ? rx_frame_start : tx_frame_start)
      |=> crc_reg == 32'hFFFF_FFFF)
   else $error("crc not preset at frame start");

   a_crc_owner: // [R11]
   assert property (@(posedge sys_clk) disable iff (sys_rst)
      loopback |-> crc_in == (crc_to_receiver_select ? rx_bit : tx_bit))
   else $error("loopback crc owner wrong");

   a_crc_active_low: // [R3]
   assert property (@(posedge sys_clk) disable iff (sys_rst)
      crc_stb && !(crc_rx_side ? rx_frame_start : tx_frame_start)
      |=> crc_out_n == ~$past(crc_next))
   else $error("crc output not inverted");

   a_resid_byte_only: // [R12]
   assert property (@(posedge sys_clk) disable iff (sys_rst)
      !rx_frame_start && !$past(rx_frame_start) && $changed(resid_ok_reg) |->
      $past(crc_stb) && $past(crc_bits_reg) == 3'h7)
   else $error("residue sampled off a byte boundary");

   a_count_saturate: // [R14]
   assert property (@(posedge sys_clk) disable iff (sys_rst)
      rx_count_reg == 12'hFFF && !rx_frame_start |=> rx_count_reg == 12'hFFF)
   else $error("byte count wrapped");

   a_stat_select: // [R4]
   assert property (@(posedge sys_clk) disable iff (sys_rst)
      stat_drive && stat_sel == 2'h3 |-> stat_bus == {4'h0, rx_count_reg})
   else $error("status select 11 not byte count");

   a_stat_pair: // [R5]
   assert property (@(posedge sys_clk) disable iff (sys_rst)
      !stat_drive ##1 stat_drive |-> !stat_sel[0] && stat_left_reg == 2'h2)
   else $error("status sequence does not open on word zero");

   a_req_held: // [R10]
   assert property (@(posedge sys_clk) disable iff (sys_rst)
      mem_req && !mem_ack |=> mem_req && $stable(mem_cmd.kind))
   else $error("memory request dropped before acknowledge");

   a_tx_word_time: // [R10]
   assert property (@(posedge sys_clk) disable iff (sys_rst)
      mem_req && mem_ack && mem_cmd.kind == lbcs_pkg::LBCS_K_TXREAD
      |=> tx_word_valid ##1 !tx_word_valid)
   else $error("transmit word not one cycle after acknowledge");
endmodule
`default_nettype wire

// File: common/lbcs_pkg.sv
// constants, types and carriers shared by the link buffer/crc/status block
package lbcs_pkg;

   // ----------------------------------------------------------------------
   // crc constants
   // ----------------------------------------------------------------------
   localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7; // generator value
   localparam logic [31:0] CRC_PRESET = 32'hFFFF_FFFF; // per-frame preset
   // residue left after a good frame, msb is the x^31 term
   localparam logic [31:0] CRC_RESIDUE = 32'hC704_DD7B;
   localparam int CRC_W = 32; // crc register width
   localparam int BYTE_BITS = 8; // residue check spacing in bits

   // ----------------------------------------------------------------------
   // buffer memory layout
   // ----------------------------------------------------------------------
   localparam int MEM_WORDS = 16384; // 16k words of packet buffer
   localparam int WORD_W = 16; // memory word width
   localparam int BUF_COUNT = 16; // fixed buffers
   localparam int BUF_BYTES = 1536; // bytes per buffer
   localparam int STAT_BYTES = 4; // status area at head of each buffer
   localparam int STAT_WORDS = STAT_BYTES / 2; // status words per buffer

   // ----------------------------------------------------------------------
   // receive counter, status fields and mux selects
   // ----------------------------------------------------------------------
   localparam int RXCNT_W = 12; // receive byte counter width
   localparam int RX_CRC_BIT = 11; // crc error bit in rx status word zero
   localparam int REFLECT_W = 10; // reflect time field in tx word one
   localparam logic [1:0] SEL_TX_W0 = 2'h0;
   localparam logic [1:0] SEL_TX_W1 = 2'h1;
   localparam logic [1:0] SEL_RX_W0 = 2'h2;
   localparam logic [1:0] SEL_RX_CNT = 2'h3;
   localparam int FIFO_DEPTH = 8; // words between shifter and memory

   // ----------------------------------------------------------------------
   // types
   // ----------------------------------------------------------------------
   // memory bus controller states, gray along idle->data->status->read
   typedef enum logic [1:0] {
      LBCS_IDLE = 2'h0,
      LBCS_DATA = 2'h1,
      LBCS_STAT = 2'h3,
      LBCS_TXRD = 2'h2
   } lbcs_mbc_e;

   // kind of link transfer the port must place
   typedef enum logic [1:0] {
      LBCS_K_RXDATA = 2'h0,
      LBCS_K_STATUS = 2'h1,
      LBCS_K_TXREAD = 2'h2
   } lbcs_kind_e;

   // request carried to the port-side arbiter
   typedef struct packed {
      lbcs_kind_e kind; // what the transfer is
      logic stat_idx; // status word index within the status area
      logic [WORD_W-1:0] wdata; // word to write
   } lbcs_memreq_s;

endpackage

// File: rtl/lbcs_fifo.sv
// small synchronous valid/ready fifo between word shifter and memory
`timescale 1ns/1ns
`default_nettype none
module lbcs_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH]; // storage
   logic [AW-1:0] wr_reg; // write pointer
   logic [AW-1:0] rd_reg; // read pointer
   logic [AW:0] cnt_reg; // occupancy
   logic push;
   logic pop;

   // honest full/empty from the occupancy count
   assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem_reg[rd_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // ----------------------------------------------------------------------
   // storage write
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data;
      end
   end

   // ----------------------------------------------------------------------
   // pointers and count
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// File: bench/lbcs_port_model.sv
// port-side model: grant, address source and status capture
`timescale 1ns/1ns
`default_nettype none
module lbcs_port_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // link side
   input wire logic mem_req,
   input wire lbcs_pkg::lbcs_memreq_s mem_cmd,
   input wire logic [15:0] stat_bus,
   input wire logic [1:0] stat_sel,
   // bench controls
   input wire logic stall,
   input wire logic [13:0] dir_addr,
   // answers
   output logic mem_ack,
   output logic [13:0] port_addr,
   output logic [15:0] st0,
   output logic [15:0] st1,
   output logic [1:0] sl0,
   output logic [1:0] sl1,
   output logic [7:0] n_st
);
   // status goes to the head of buffer one; other transfers use the bench address
   assign port_addr = (mem_cmd.kind == lbcs_pkg::LBCS_K_STATUS) ?
      14'h0300 + 14'(mem_cmd.stat_idx) : dir_addr;
   // one-cycle grant to a held request, never two cycles running, none while stalled
   always_ff @(posedge sys_clk) begin
      mem_ack <= !sys_rst && mem_req && !mem_ack && !stall;
   end
   // capture each status word as it moves
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         n_st <= 8'h00;
      end else if (mem_req && mem_ack &&
                   mem_cmd.kind == lbcs_pkg::LBCS_K_STATUS) begin
         n_st <= n_st + 8'h01;
         if (mem_cmd.stat_idx) begin
            st1 <= stat_bus;
            sl1 <= stat_sel;
         end else begin
            st0 <= stat_bus;
            sl0 <= stat_sel;
         end
      end
   end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the link crc, status and buffer block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   // ----------------------------------------
   // stimulus and wiring
   // ----------------------------------------
   logic sys_clk = 0, sys_rst = 1, lpb = 0, rsel = 0, tx_act = 0, tx_fs = 0;
   logic tx_stb = 0, tx_b = 0, tx_dn = 0, tx_rq = 0, rx_act = 0, rx_fs = 0;
   logic rx_stb = 0, rx_b = 0, rx_fe = 0, p_en = 0, p_we = 0, stall = 0;
   logic [15:0] ts0 = 0, ts1 = 0, pwd = 0, txw, st0, st1, sbus, prd;
   logic [9:0] crt = 0;
   logic [13:0] daddr = 0, paddr;
   logic [31:0] crc_n;
   logic [1:0] sl0, sl1, ssel;
   logic [7:0] n_st, m;
   logic mreq, mack, txv, crc_err, ovr, sdrv;
   lbcs_pkg::lbcs_memreq_s mcmd;
   int miscompares = 0, n_tests = 0;
   initial forever #10 sys_clk = ~sys_clk;
   lbcs_link i_dut (.sys_clk, .sys_rst, .loopback(lpb),
      .crc_to_receiver_select(rsel), .tx_active(tx_act),
      .tx_frame_start(tx_fs), .tx_bit_stb(tx_stb), .tx_bit(tx_b),
      .tx_done(tx_dn), .tx_stat0(ts0), .tx_stat1(ts1),
      .cable_reflect_time(crt), .tx_word_req(tx_rq), .tx_word_valid(txv),
      .tx_word(txw), .rx_active(rx_act), .rx_frame_start(rx_fs),
      .rx_bit_stb(rx_stb), .rx_bit(rx_b), .rx_frame_end(rx_fe),
      .crc_out_n(crc_n), .crc_error(crc_err), .rx_overrun(ovr),
      .mem_req(mreq), .mem_cmd(mcmd), .mem_ack(mack), .port_addr(paddr),
      .port_en(p_en), .port_we(p_we), .port_wdata(pwd), .port_rdata(prd),
      .stat_sel(ssel), .stat_drive(sdrv), .stat_bus(sbus));
   lbcs_port_model i_port (.sys_clk, .sys_rst, .mem_req(mreq),
      .mem_cmd(mcmd), .stat_bus(sbus), .stat_sel(ssel), .stall,
      .dir_addr(daddr), .mem_ack(mack), .port_addr(paddr), .st0, .st1,
      .sl0, .sl1, .n_st);
   // ----------------------------------------
   // shared helpers
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask
   task automatic chk(input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // serial msb-first update, kept apart from the design's own logic
   function automatic logic [31:0] nx(input logic [31:0] c, input logic b);
      return {c[30:0], 1'b0} ^ ((c[31] ^ b) ? lbcs_pkg::CRC_POLY : 32'h0);
   endfunction
   task automatic wait_pair();
      repeat (400) if (n_st != m + 8'h02) tick(1);
      chk(32'(n_st), 32'(m + 8'h02));
   endtask
   // direct port read, data taken one edge after the address
   task automatic rd(input logic [13:0] a, input logic [15:0] e);
      {p_en, p_we, daddr} = {2'b10, a};
      tick(1);
      chk(32'(prd), 32'(e));
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_txcrc();
      logic [31:0] c;
      c = lbcs_pkg::CRC_PRESET;
      {lpb, rx_act, tx_act} = 3'b111; // loopback, crc must stay on tx
      tx_fs = 1;
      tick(1);
      tx_fs = 0;
      for (int k = 0; k < 8; k++) begin
         c = nx(c, k[0]);
         tx_stb = 1;
         tx_b = k[0];
         tick(1);
         tx_stb = 0;
         tick(1);
      end
      chk(crc_n, ~c);
      tx_act = 0;
      $display("tx crc test done");
   endtask
   // frame of n bytes plus check field, last bit flipped when bad
   task automatic rx_frame(input int n, input logic bad, lp, stl);
      logic [31:0] c;
      logic [7:0] d;
      c = lbcs_pkg::CRC_PRESET;
      m = n_st;
      {lpb, rsel, stall, rx_act, rx_fs} = {lp, lp, stl, 2'b11};
      tick(1);
      rx_fs = 0;
      for (int i = 0; i < n + 4; i++) begin
         d = (i < n) ? 8'(i * 37 + 5) : 8'h00;
         for (int k = 0; k < 8; k++) begin
            if (i < n) c = nx(c, d[k]);
            rx_b = (i < n) ? d[k] : ~c[31 - ((i - n) * 8 + k)];
            if (bad && i == n + 3 && k == 7) rx_b = ~rx_b;
            rx_stb = 1;
            tick(1);
            rx_stb = 0;
            tick(1);
         end
      end
      rx_fe = 1;
      tick(1);
      {rx_fe, rx_act, stall} = 3'b000;
      wait_pair();
      chk(32'(crc_err), 32'(bad));
      chk(32'(st0), 32'(bad) << lbcs_pkg::RX_CRC_BIT);
      chk(32'(st1), 32'(n + 4));
      chk({sl0, sl1}, {lbcs_pkg::SEL_RX_W0, lbcs_pkg::SEL_RX_CNT});
      chk(32'(ovr), 32'(stl));
      $display("rx frame test done");
   endtask
   task automatic t_tx();
      {p_en, p_we, daddr, pwd} = {2'b11, 14'h0302, 16'hBEEF};
      tick(1);
      {p_en, p_we, ts0, ts1, crt} = {2'b00, 16'h1234, 16'hA800, 10'h2A5};
      m = n_st;
      tx_dn = 1;
      tick(1);
      tx_dn = 0;
      wait_pair();
      chk({st0, st1}, {16'h1234, 6'h2A, 10'h2A5});
      chk({sl0, sl1}, {lbcs_pkg::SEL_TX_W0, lbcs_pkg::SEL_TX_W1});
      tx_rq = 1;
      tick(1);
      tx_rq = 0;
      repeat (20) if (txv !== 1'b1) tick(1);
      chk({txv, txw}, {1'b1, 16'hBEEF});
      // last kept word of the stalled frame: bytes 15 and 14
      rd(14'h0000, 16'h300B);
      rd(14'h0301, 16'hAAA5);
      p_en = 0;
      $display("tx status and read test done");
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // watchdog, well past the several hundred cycles the tests need
   initial begin
      #400_000;
      miscompares++;
      conclude();
   end
   initial begin
      tick(12);
      sys_rst = 0;
      chk(crc_n, 32'h0);
      chk({mreq, sdrv, txv, crc_err, ovr}, 32'h0);
      t_txcrc();
      rx_frame(7, 0, 1, 0);
      rx_frame(24, 1, 0, 1);
      t_tx();
      conclude();
   end
endmodule
`default_nettype wire
